// ==== rtl/fpe_erase_ctrl.sv ====
//////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the APB register port and the register addresses.
module fpe_erase_ctrl #(
    parameter int NUM_PAGES = fpe_pkg::NUM_PAGES,
    parameter int PAGE_WORDS = fpe_pkg::PAGE_WORDS
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // User logic erase request
    input wire logic page_erase_request_i,
    input wire logic [fpe_pkg::PAGE_AW-1:0] page_addr_i,
    input wire logic overwrite_protect_select_i,
    input wire logic page_loss_guard_i,
    input wire logic [fpe_pkg::PAGE_AW-1:0] buffer_page_i,
    input wire logic ecc_uncorr_i,
    // Completion
    output logic busy_o,
    output logic done_o,
    output logic [1:0] status_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt
    output logic irq_o
);
    import fpe_pkg::*;

    fpe_state_t state_r;
    fpe_req_t req_r;
    fpe_apb_req_t apb;
    logic [WORD_AW-1:0] idx_r;
    logic ecc_seen_r;
    logic busy_r, done_r, irq_r, pready_r, pslverr_r;
    logic [1:0] status_r;
    logic [31:0] prdata_r;
    logic [CNT_W-1:0] thresh_r;
    logic [3:0] irq_stat_r, irq_mask_r, irq_set;
    logic [NUM_PAGES-1:0] protect_r;
    logic [DATA_W-1:0] rd_data;
    logic [CNT_W-1:0] cnt;
    logic refuse, last_word, wr_en, clr, cnt_inc, bad_word;
    logic [1:0] final_status;

    // Decodes an APB offset into a mapped-or-not flag
    function automatic logic is_mapped(input logic [7:0] a);
        return a == REG_THRESH || a == REG_IRQ_STAT || a == REG_IRQ_MASK ||
               a == REG_PROTECT || a == REG_RESULT;
    endfunction

    assign apb = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                   paddr: paddr_i, pwdata: pwdata_i};

    //////////////////////////////////////////////////////////////////////////////
    // Page store
    fpe_page_store #(
        .NUM_PAGES(NUM_PAGES),
        .PAGE_WORDS(PAGE_WORDS),
        .DATA_W(DATA_W),
        .CNT_W(CNT_W)
    ) u_store (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .clr_i(clr),
        .page_i(req_r.page),
        .word_i(idx_r),
        .cnt_inc_i(cnt_inc),
        .rd_data_o(rd_data),
        .cnt_o(cnt)
    );

    //////////////////////////////////////////////////////////////////////////////
    // Sequencer decisions
    assign refuse = protect_r[req_r.page] ||
                    (req_r.loss_guard && req_r.buf_page != req_r.page);
    assign last_word = idx_r == WORD_AW'(PAGE_WORDS - 1);
    assign clr = state_r == FPE_ERASE;
    assign cnt_inc = clr && last_word;
    assign bad_word = rd_data != '0 || ecc_uncorr_i;
    // ECC outranks wear: a page that cannot be read back matters more
    assign final_status = (ecc_seen_r || bad_word) ? ST_ECC :
                          (cnt > thresh_r) ? ST_WCNT : ST_OK;

    // Main erase sequence
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= FPE_IDLE;
            req_r <= '0;
            idx_r <= '0;
            ecc_seen_r <= 1'b0;
        end else if (ce_i) begin
            unique case (state_r)
                FPE_IDLE: begin
                    if (page_erase_request_i) begin
                        req_r <= '{page: page_addr_i, ow_sel: overwrite_protect_select_i,
                                   loss_guard: page_loss_guard_i, buf_page: buffer_page_i};
                        state_r <= FPE_CHECK;
                    end
                end
                FPE_CHECK: begin
                    idx_r <= '0;
                    ecc_seen_r <= 1'b0;
                    state_r <= refuse ? FPE_DONE : FPE_ERASE;
                end
                FPE_ERASE: begin
                    idx_r <= last_word ? '0 : idx_r + 1'b1;
                    if (last_word) begin
                        state_r <= FPE_VERIFY;
                    end
                end
                FPE_VERIFY: begin
                    idx_r <= idx_r + 1'b1;
                    ecc_seen_r <= ecc_seen_r || bad_word;
                    if (last_word) begin
                        state_r <= FPE_DONE;
                    end
                end
                FPE_DONE: begin
                    state_r <= FPE_IDLE;
                end
                default: begin
                    state_r <= FPE_IDLE;
                end
            endcase
        end
    end

    // Completion outputs straight from flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            status_r <= ST_OK;
        end else if (ce_i) begin
            done_r <= 1'b0;
            if (state_r == FPE_IDLE && page_erase_request_i) begin
                busy_r <= 1'b1;
            end else if (state_r == FPE_DONE) begin
                busy_r <= 1'b0;
            end
            if (state_r == FPE_CHECK && refuse) begin
                status_r <= ST_REFUSED;
                done_r <= 1'b1;
            end else if (state_r == FPE_VERIFY && last_word) begin
                status_r <= final_status;
                done_r <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, read data latched with pready
    assign wr_en = apb.psel && apb.penable && pready_r && apb.pwrite;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else if (ce_i) begin
            pready_r <= apb.psel && apb.penable && !pready_r;
            pslverr_r <= apb.psel && apb.penable && !pready_r && !is_mapped(apb.paddr);
            if (apb.psel && apb.penable && !pready_r && !apb.pwrite) begin
                unique case (apb.paddr)
                    REG_THRESH: prdata_r <= 32'(thresh_r);
                    REG_IRQ_STAT: prdata_r <= 32'(irq_stat_r);
                    REG_IRQ_MASK: prdata_r <= 32'(irq_mask_r);
                    REG_PROTECT: prdata_r <= 32'(protect_r);
                    REG_RESULT: prdata_r <= 32'({busy_r, req_r.page, status_r});
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            thresh_r <= THRESH_RST;
            irq_mask_r <= IRQ_MASK_RST;
        end else if (ce_i && wr_en) begin
            if (apb.paddr == REG_THRESH) begin
                thresh_r <= apb.pwdata[CNT_W-1:0];
            end
            if (apb.paddr == REG_IRQ_MASK) begin
                irq_mask_r <= apb.pwdata[3:0];
            end
        end
    end

    // Protection map; erase with overwrite select set leaves the page protected
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            protect_r <= PROTECT_RST;
        end else if (ce_i) begin
            if (wr_en && apb.paddr == REG_PROTECT) begin
                protect_r <= apb.pwdata[NUM_PAGES-1:0];
            end
            if (state_r == FPE_VERIFY && last_word && req_r.ow_sel) begin
                protect_r[req_r.page] <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, write one to clear, set wins
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DONE] = done_r;
        irq_set[IRQ_REFUSED] = done_r && status_r == ST_REFUSED;
        irq_set[IRQ_ECC] = done_r && status_r == ST_ECC;
        irq_set[IRQ_WCNT] = done_r && status_r == ST_WCNT;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else if (ce_i) begin
            irq_stat_r <= (irq_stat_r & ~((wr_en && apb.paddr == REG_IRQ_STAT) ?
                           apb.pwdata[3:0] : 4'h0)) | irq_set;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;
    assign status_o = status_r;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign irq_o = irq_r;

    //////////////////////////////////////////////////////////////////////////////
    // Checks
    request_start_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_IDLE && ce_i && page_erase_request_i |=> busy_o)
        else $error("erase request not taken");

    refuse_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_CHECK && ce_i && refuse |=> done_o && status_o == ST_REFUSED)
        else $error("refused erase without status 01");

    refuse_no_clear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_CHECK && ce_i && refuse |=> state_r != FPE_ERASE)
        else $error("refused page still cleared");

    // Watches the outcome, not the refuse term itself
    loss_guard_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_CHECK && ce_i && req_r.loss_guard && req_r.buf_page != req_r.page
        |=> state_r == FPE_DONE && status_o == ST_REFUSED)
        else $error("page loss guard ignored");

    // Every word read back during verify has already been cleared
    verify_zero_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_VERIFY && ce_i |-> rd_data == '0)
        else $error("cleared word not zero");

    ecc_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_VERIFY && ce_i && ecc_uncorr_i |-> ##[1:8] done_o && status_o == ST_ECC)
        else $error("ecc error not reported");

    wcnt_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_VERIFY && ce_i && last_word && !ecc_seen_r && !bad_word &&
        cnt > thresh_r |=> status_o == ST_WCNT)
        else $error("wear threshold not reported");

    clean_code_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        done_o && status_o == ST_OK |-> !$past(refuse) || $past(state_r) != FPE_CHECK)
        else $error("clean status after refusal");

    done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && done_o |=> !done_o)
        else $error("done wider than one cycle");

    busy_drop_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        state_r == FPE_DONE && ce_i |=> !busy_o)
        else $error("busy kept after completion");

    // Event bits must land even when software clears in the same cycle
    sticky_set_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && |irq_set |=> (irq_stat_r & $past(irq_set)) == $past(irq_set))
        else $error("status event lost");

    irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && |(irq_stat_r & irq_mask_r) |=> irq_o || !$past(ce_i))
        else $error("masked-in status without interrupt");

    apb_wait_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ce_i && psel_i && penable_i && !pready_o |=> pready_o)
        else $error("apb access not answered");
endmodule

// ==== rtl/fpe_pkg.sv ====
package fpe_pkg;

    // Array geometry
    localparam int NUM_PAGES = 8;
    localparam int PAGE_WORDS = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;
    localparam int PAGE_AW = $clog2(NUM_PAGES);
    localparam int WORD_AW = $clog2(PAGE_WORDS);

    // Completion status codes
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_REFUSED = 2'h1;
    localparam logic [1:0] ST_ECC = 2'h2;
    localparam logic [1:0] ST_WCNT = 2'h3;

    // Register byte offsets
    localparam logic [7:0] REG_THRESH = 8'h00;
    localparam logic [7:0] REG_IRQ_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_PROTECT = 8'h0C;
    localparam logic [7:0] REG_RESULT = 8'h10;

    // Reset values
    localparam logic [CNT_W-1:0] THRESH_RST = 8'hC8;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [NUM_PAGES-1:0] PROTECT_RST = 8'h00;

    // Interrupt bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_ECC = 2;
    localparam int IRQ_WCNT = 3;

    // Sequencer states, Gray coded from IDLE through DONE; DONE back to IDLE flips two bits
    typedef enum logic [2:0] {
        FPE_IDLE = 3'b000,
        FPE_CHECK = 3'b001,
        FPE_ERASE = 3'b011,
        FPE_VERIFY = 3'b010,
        FPE_DONE = 3'b110
    } fpe_state_t;

    // Erase request as taken from user logic
    typedef struct packed {
        logic [PAGE_AW-1:0] page;
        logic ow_sel;
        logic loss_guard;
        logic [PAGE_AW-1:0] buf_page;
    } fpe_req_t;

    // APB request group
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fpe_apb_req_t;

endpackage

// ==== rtl/fpe_page_store.sv ====
module fpe_page_store #(
    parameter int NUM_PAGES = 8,
    parameter int PAGE_WORDS = 4,
    parameter int DATA_W = 32,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Erase port
    input wire logic clr_i,
    input wire logic [$clog2(NUM_PAGES)-1:0] page_i,
    input wire logic [$clog2(PAGE_WORDS)-1:0] word_i,
    input wire logic cnt_inc_i,
    // Read back
    output logic [DATA_W-1:0] rd_data_o,
    output logic [CNT_W-1:0] cnt_o
);
    localparam int DEPTH = NUM_PAGES * PAGE_WORDS;
    localparam int AW = $clog2(DEPTH);

    logic [DATA_W-1:0] mem_r [DEPTH];
    logic [CNT_W-1:0] cnt_r [NUM_PAGES];
    logic [AW-1:0] addr;

    assign addr = {page_i, word_i};

    // Array has no reset; the sequencer reads only words it just cleared
    always_ff @(posedge ref_clk_i) begin
        if (ce_i && clr_i) begin
            mem_r[addr] <= '0;
        end
    end

    // Per-page write counters, saturating so wear never wraps to small
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NUM_PAGES; i++) begin
                cnt_r[i] <= '0;
            end
        end else if (ce_i && cnt_inc_i && cnt_r[page_i] != '1) begin
            cnt_r[page_i] <= cnt_r[page_i] + 1'b1;
        end
    end

    assign rd_data_o = mem_r[addr];
    assign cnt_o = cnt_r[page_i];
endmodule

// ==== bench/fpe_user_model.sv ====
module fpe_user_model
    import fpe_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Bench command
    input wire logic go_i,
    input fpe_pkg::fpe_req_t cmd_i,
    input wire logic ecc_i,
    // Block status
    input wire logic busy_i,
    input wire logic done_i,
    // Request towards the block
    output fpe_pkg::fpe_req_t req_o,
    output logic request_o,
    output logic ecc_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import fpe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Request held until busy is seen, so a slow block cannot miss it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            request_o <= 1'b0;
            req_o <= '0;
        end else if (go_i && !request_o) begin
            request_o <= 1'b1;
            req_o <= cmd_i;
        end else if (request_o && busy_i) begin
            request_o <= 1'b0;
            // Released qualifiers must not keep their old value
            req_o <= ~req_o;
        end
    end

    // Fabric ECC flag stands for the whole operation, drops at completion
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ecc_o <= 1'b0;
        end else if (go_i && !request_o) begin
            ecc_o <= ecc_i;
        end else if (done_i) begin
            ecc_o <= 1'b0;
        end
    end
endmodule

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import fpe_pkg::*;

    logic clk = 1'b0;
    logic ce = 1'b1;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic ecc_cmd = 1'b0;
    fpe_req_t cmd = '0;
    fpe_req_t req;
    fpe_apb_req_t apb = '0;
    logic request, ecc, busy_o, done_o, pready_o, pslverr_o, irq_o;
    logic [1:0] status_o;
    logic [31:0] prdata_o;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int n_compared = 0;

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    fpe_erase_ctrl fpe_erase_ctrl_inst (
        .ref_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce),
        .page_erase_request_i(request), .page_addr_i(req.page),
        .overwrite_protect_select_i(req.ow_sel), .page_loss_guard_i(req.loss_guard),
        .buffer_page_i(req.buf_page), .ecc_uncorr_i(ecc),
        .busy_o(busy_o), .done_o(done_o), .status_o(status_o),
        .psel_i(apb.psel), .penable_i(apb.penable), .pwrite_i(apb.pwrite),
        .paddr_i(apb.paddr), .pwdata_i(apb.pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o)
    );

    fpe_user_model fpe_user_model_inst (
        .ref_clk_i(clk), .arst_n_i(rst_n), .go_i(go), .cmd_i(cmd), .ecc_i(ecc_cmd),
        .busy_i(busy_o), .done_i(done_o), .req_o(req), .request_o(request), .ecc_o(ecc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer; read data and error taken at the pready edge only
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        apb <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        rd = prdata_o;
        err = pslverr_o;
        if (n >= 50) n_errors++;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // One erase through the user model; latency counted from the taking edge
    task automatic erase(input logic [2:0] pg, input logic ow, input logic gd,
                         input logic [2:0] bp, input logic ec, input logic [1:0] st,
                         input int lat);
        int n;
        n = 0;
        @(posedge clk);
        cmd <= '{page:pg, ow_sel:ow, loss_guard:gd, buf_page:bp};
        ecc_cmd <= ec;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 60);
        check(n, lat);
        check(status_o, st);
        @(posedge clk);
        #1;
        check({done_o, busy_o}, 2'b00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb_xfer(1'b0, REG_THRESH, 32'h0);
        check(rd, 32'h000000C8);
        apb_xfer(1'b0, REG_PROTECT, 32'h0);
        check(rd, 32'h0);
        // Unmapped place: error, reads zero
        apb_xfer(1'b0, 8'h14, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask

    task automatic t_clean();
        erase(3'h2, 1'b0, 1'b0, 3'h0, 1'b0, ST_OK, 10);
        apb_xfer(1'b0, REG_RESULT, 32'h0);
        check(rd, 32'h00000008);
    endtask

    task automatic t_protect();
        erase(3'h3, 1'b1, 1'b0, 3'h0, 1'b0, ST_OK, 10);
        apb_xfer(1'b0, REG_PROTECT, 32'h0);
        check(rd, 32'h00000008);
        // No erase cycles spent: page left as it was
        erase(3'h3, 1'b0, 1'b0, 3'h0, 1'b0, ST_REFUSED, 2);
    endtask

    task automatic t_guard();
        erase(3'h4, 1'b0, 1'b1, 3'h5, 1'b0, ST_REFUSED, 2);
        erase(3'h4, 1'b0, 1'b1, 3'h4, 1'b0, ST_OK, 10);
        erase(3'h1, 1'b0, 1'b0, 3'h7, 1'b0, ST_OK, 10);
    endtask

    task automatic t_ecc_wear();
        erase(3'h5, 1'b0, 1'b0, 3'h0, 1'b1, ST_ECC, 10);
        apb_xfer(1'b1, REG_THRESH, 32'h2);
        erase(3'h6, 1'b0, 1'b0, 3'h0, 1'b0, ST_OK, 10);
        erase(3'h6, 1'b0, 1'b0, 3'h0, 1'b0, ST_OK, 10);
        erase(3'h6, 1'b0, 1'b0, 3'h0, 1'b0, ST_WCNT, 10);
        erase(3'h6, 1'b0, 1'b0, 3'h0, 1'b1, ST_ECC, 10);
    endtask

    // Sticky status, mask gating and write-one-to-clear
    task automatic t_irq();
        apb_xfer(1'b0, REG_IRQ_STAT, 32'h0);
        check(rd, 32'h0000000F);
        check(irq_o, 1'b0);
        apb_xfer(1'b1, REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        #1;
        check(irq_o, 1'b1);
        apb_xfer(1'b1, REG_IRQ_STAT, 32'h4);
        repeat (2) @(posedge clk);
        #1;
        check(irq_o, 1'b0);
        apb_xfer(1'b0, REG_IRQ_STAT, 32'h0);
        check(rd, 32'h0000000B);
    endtask

    // Enable low right after the request is taken, in FPE_CHECK, freezes the sequence; it resumes where it stopped
    task automatic t_freeze();
        int n;
        n = 0;
        @(posedge clk);
        cmd <= '{page:3'h7, ow_sel:1'b0, loss_guard:1'b0, buf_page:3'h0};
        ecc_cmd <= 1'b0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        check({done_o, busy_o}, 2'b01);
        ce <= 1'b1;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 60);
        check(n, 9);
        check(status_o, ST_OK);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_clean();
        t_protect();
        t_guard();
        t_ecc_wear();
        t_irq();
        t_freeze();
        wrap_up();
    end

    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule
